/* pkg/dsw_pkg.sv */
package dsw_pkg;

	// Register byte offsets
	localparam logic [7:0] DSW_OFS_CTRL = 8'h00;
	localparam logic [7:0] DSW_OFS_TOUT1 = 8'h04;
	localparam logic [7:0] DSW_OFS_TOUT2 = 8'h08;
	localparam logic [7:0] DSW_OFS_SERVICE = 8'h0C;
	localparam logic [7:0] DSW_OFS_STATUS = 8'h10;
	localparam logic [7:0] DSW_OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] DSW_OFS_IRQ_EN = 8'h18;
	localparam logic [7:0] DSW_OFS_IRQ_CLR = 8'h1C;
	localparam logic [7:0] DSW_OFS_PRESCALE = 8'h20;

	// Service key written to the service register
	localparam logic [31:0] DSW_SERVICE_KEY = 32'h0000_5A5A;

	// Control field positions
	localparam int DSW_CTRL_EN_BIT = 0;
	localparam int DSW_CTRL_ACT1_LSB = 4;
	localparam int DSW_CTRL_ACT2_LSB = 8;
	localparam int DSW_CTRL_PINSEL_BIT = 12;
	localparam int DSW_ACT_W = 3;

	// Interrupt status bit positions
	localparam int DSW_IRQ_STAGE1 = 0;
	localparam int DSW_IRQ_STAGE2 = 1;
	localparam int DSW_IRQ_W = 2;

	// Reset values
	localparam logic [31:0] DSW_TOUT_RST = 32'h0000_03E8;
	localparam logic [31:0] DSW_PRESCALE_RST = 32'h0000_61A7;

	// Reset pulse length in system clocks
	localparam logic [7:0] DSW_RESET_PULSE = 8'h10;

	typedef enum logic [DSW_ACT_W-1:0] {
		DSW_ACT_RESET,
		DSW_ACT_NMI,
		DSW_ACT_OSINT,
		DSW_ACT_DELAY,
		DSW_ACT_PIN,
		DSW_ACT_CASCADE
	} dsw_action_type;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} dsw_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dsw_apb_rsp_type;

endpackage

/* design/dsw_tick_div.sv */
`timescale 1ns/100ps
// One-cycle tick every (reload+1) system clocks
module dsw_tick_div
	import dsw_pkg::*;
#(
	parameter int WIDTH = 32
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] reload,
	output logic tick
);

	initial
	begin
		if (WIDTH < 2)
			$error("dsw_tick_div: WIDTH too small");
	end

	logic [WIDTH-1:0] count_q;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			count_q <= '0;
			tick <= 1'b0;
		end
		else if (count_q >= reload)
		begin
			count_q <= '0;
			tick <= 1'b1;
		end
		else
		begin
			count_q <= count_q + 1'b1;
			tick <= 1'b0;
		end
	end

endmodule

/* design/dsw_watchdog.sv */
`timescale 1ns/100ps
// Summary of operation
// R1 - Two stages, each configured separately, run one after the other.
// R2 - Unserviced expiry of a stage performs that stage's configured action.
// R3 - Reset action pulses a whole-module reset output.
// R4 - Non-maskable interrupt action raises a non-maskable interrupt output.
// R5 - OS control interrupt action raises an OS-visible interrupt.
// R6 - Delay action exists for stage one only; stage two treats it as none. The code decodes delay to no output in either stage.
// R7 - Signal-only action asserts the expiry pin and nothing else.
// R8 - Cascade takes no action but starts stage two after its time-out.
// R9 - Software selects which stage drives the expiry pin.
// R10 - Expiry pin clears only on reset; software cannot clear it.
// R11 - Service reloads stage one, returning to it from stage two; stage two starts when stage one expires.
// R12 - After the last stage acts, stay idle until re-armed or reset.
module dsw_watchdog
	import dsw_pkg::*;
#(
	parameter int TOUT_W = 32
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire dsw_apb_req_type apbReq,
	output dsw_apb_rsp_type apbRsp,
	output logic moduleReset,
	output logic nmiOut,
	output logic os_control_interrupt,
	output logic watchdog_expiry_pin,
	output logic irq
);

	initial
	begin
		if (TOUT_W < 2 || TOUT_W > 32)
			$error("dsw_watchdog: TOUT_W out of range");
	end

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_STAGE1,
		ST_STAGE2,
		ST_DONE
	} dsw_state_type;

	dsw_state_type state_q;
	logic enable_q;
	dsw_action_type act1_q;
	dsw_action_type act2_q;
	logic pinSel_q;
	logic [TOUT_W-1:0] tout1_q;
	logic [TOUT_W-1:0] tout2_q;
	logic [TOUT_W-1:0] count_q;
	logic [31:0] prescale_q;
	logic [DSW_IRQ_W-1:0] irqStat_q;
	logic [DSW_IRQ_W-1:0] irqEn_q;
	logic [7:0] rstCount_q;
	logic nmi_q;
	logic osInt_q;
	logic pin_q;
	logic tick;
	logic wrEn;
	logic rdEn;
	logic serviceWr;
	logic armWr;
	logic expire1;
	logic expire2;
	logic [DSW_IRQ_W-1:0] irqSet;
	logic [DSW_IRQ_W-1:0] irqClr;
	logic [31:0] rdData;
	logic addrOk;
	logic [31:0] prdata_q;

	dsw_tick_div #(
		.WIDTH(32)
	) u_div (
		.clk_sys(clk_sys),
		.rst(rst),
		.reload(prescale_q),
		.tick(tick)
	);

	// APB: zero-wait slave, error on unmapped address
	assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign rdEn = apbReq.psel && apbReq.penable && !apbReq.pwrite;

	always_comb
	begin
		addrOk = 1'b1;
		rdData = '0;
		case (apbReq.paddr)
			DSW_OFS_CTRL:
			begin
				rdData[DSW_CTRL_EN_BIT] = enable_q;
				rdData[DSW_CTRL_ACT1_LSB +: DSW_ACT_W] = act1_q;
				rdData[DSW_CTRL_ACT2_LSB +: DSW_ACT_W] = act2_q;
				rdData[DSW_CTRL_PINSEL_BIT] = pinSel_q;
			end
			DSW_OFS_TOUT1: rdData[TOUT_W-1:0] = tout1_q;
			DSW_OFS_TOUT2: rdData[TOUT_W-1:0] = tout2_q;
			DSW_OFS_SERVICE: rdData = '0;
			DSW_OFS_STATUS:
			begin
				rdData[TOUT_W-1:0] = count_q;
			end
			DSW_OFS_IRQ_STAT: rdData[DSW_IRQ_W-1:0] = irqStat_q;
			DSW_OFS_IRQ_EN: rdData[DSW_IRQ_W-1:0] = irqEn_q;
			DSW_OFS_IRQ_CLR: rdData = '0;
			DSW_OFS_PRESCALE: rdData = prescale_q;
			default: addrOk = 1'b0;
		endcase
	end

	// One driver for the whole response word
	assign apbRsp = '{prdata: prdata_q, pready: 1'b1,
		pslverr: apbReq.psel && apbReq.penable && !addrOk};

	// Data output from a flop, loaded during the setup phase
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			prdata_q <= '0;
		else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite)
			prdata_q <= rdData;
	end

	// Configuration registers
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			act1_q <= DSW_ACT_RESET;
			act2_q <= DSW_ACT_RESET;
			pinSel_q <= 1'b0;
			tout1_q <= DSW_TOUT_RST[TOUT_W-1:0];
			tout2_q <= DSW_TOUT_RST[TOUT_W-1:0];
			prescale_q <= DSW_PRESCALE_RST;
			irqEn_q <= '0;
		end
		else if (wrEn)
		begin
			case (apbReq.paddr)
				DSW_OFS_CTRL:
				begin
					act1_q <= dsw_action_type'(
						apbReq.pwdata[DSW_CTRL_ACT1_LSB +: DSW_ACT_W]);
					act2_q <= dsw_action_type'(
						apbReq.pwdata[DSW_CTRL_ACT2_LSB +: DSW_ACT_W]);
					pinSel_q <= apbReq.pwdata[DSW_CTRL_PINSEL_BIT]; // R9
				end
				DSW_OFS_TOUT1: tout1_q <= apbReq.pwdata[TOUT_W-1:0]; // R1
				DSW_OFS_TOUT2: tout2_q <= apbReq.pwdata[TOUT_W-1:0]; // R1
				DSW_OFS_IRQ_EN: irqEn_q <= apbReq.pwdata[DSW_IRQ_W-1:0];
				DSW_OFS_PRESCALE: prescale_q <= apbReq.pwdata;
				default: ;
			endcase
		end
	end

	assign armWr = wrEn && apbReq.paddr == DSW_OFS_CTRL
		&& apbReq.pwdata[DSW_CTRL_EN_BIT];
	assign serviceWr = wrEn && apbReq.paddr == DSW_OFS_SERVICE
		&& apbReq.pwdata == DSW_SERVICE_KEY;

	// Expiry on a tick that finds the active count already at zero
	assign expire1 = state_q == ST_STAGE1 && tick && count_q == '0
		&& !serviceWr; // R2
	assign expire2 = state_q == ST_STAGE2 && tick && count_q == '0
		&& !serviceWr; // R2

	// Stage sequencer
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			count_q <= '0;
			enable_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_IDLE, ST_DONE:
				begin
					if (armWr) // R12
					begin
						state_q <= ST_STAGE1;
						count_q <= tout1_q;
						enable_q <= 1'b1;
					end
				end
				ST_STAGE1:
				begin
					if (serviceWr)
						count_q <= tout1_q; // R11
					else if (expire1)
					begin
						state_q <= ST_STAGE2; // R1 R11 R8 R6
						count_q <= tout2_q;
					end
					else if (tick)
						count_q <= count_q - 1'b1;
				end
				ST_STAGE2:
				begin
					// Service falls back to stage one
					if (serviceWr)
					begin
						state_q <= ST_STAGE1; // R11
						count_q <= tout1_q;
					end
					else if (expire2)
					begin
						state_q <= ST_DONE; // R12
						enable_q <= 1'b0;
					end
					else if (tick)
						count_q <= count_q - 1'b1;
				end
				default:
					state_q <= ST_IDLE;
			endcase
			if (armWr)
			begin
				// Arming while running restarts stage one
				state_q <= ST_STAGE1; // R12
				count_q <= tout1_q;
				enable_q <= 1'b1;
			end
			else if (wrEn && apbReq.paddr == DSW_OFS_CTRL)
			begin
				state_q <= ST_IDLE;
				enable_q <= 1'b0;
			end
		end
	end

	// Module reset pulse; held for a fixed number of clocks
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			rstCount_q <= '0;
		else if ((expire1 && act1_q == DSW_ACT_RESET)
			|| (expire2 && act2_q == DSW_ACT_RESET))
			rstCount_q <= DSW_RESET_PULSE; // R3
		else if (rstCount_q != '0)
			rstCount_q <= rstCount_q - 1'b1;
	end
	assign moduleReset = rstCount_q != '0;

	// Interrupt lines hold until the stage is serviced or re-armed
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			nmi_q <= 1'b0;
			osInt_q <= 1'b0;
		end
		else
		begin
			if ((expire1 && act1_q == DSW_ACT_NMI)
				|| (expire2 && act2_q == DSW_ACT_NMI))
				nmi_q <= 1'b1; // R4
			else if (serviceWr || armWr)
				nmi_q <= 1'b0;
			if ((expire1 && act1_q == DSW_ACT_OSINT)
				|| (expire2 && act2_q == DSW_ACT_OSINT))
				osInt_q <= 1'b1; // R5
			else if (serviceWr || armWr)
				osInt_q <= 1'b0;
		end
	end
	assign nmiOut = nmi_q;
	assign os_control_interrupt = osInt_q;

	// Expiry pin: set by selected stage or signal-only action; reset only
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			pin_q <= 1'b0; // R10
		else if ((expire1 && (!pinSel_q || act1_q == DSW_ACT_PIN))
			|| (expire2 && (pinSel_q || act2_q == DSW_ACT_PIN)))
			pin_q <= 1'b1; // R7 R9
	end
	assign watchdog_expiry_pin = pin_q;

	// Stage two ignores delay: that code decodes to no output

	// Sticky expiry status; set wins over clear
	assign irqSet = {expire2, expire1};
	assign irqClr = (wrEn && apbReq.paddr == DSW_OFS_IRQ_CLR)
		? apbReq.pwdata[DSW_IRQ_W-1:0] : '0;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			irqStat_q <= '0;
		else
			irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
	end
	assign irq = |(irqStat_q & irqEn_q);

endmodule

/* test/dsw_props.sv */
`timescale 1ns/100ps
module dsw_props
	import dsw_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire dsw_apb_req_type apbReq,
	input wire dsw_apb_rsp_type apbRsp,
	input wire logic moduleReset,
	input wire logic nmiOut,
	input wire logic os_control_interrupt,
	input wire logic watchdog_expiry_pin
);
	logic [7:0] len_q;
	wire acc = apbReq.psel && apbReq.penable;
	wire wr = acc && apbReq.pwrite;
	// Counter, since a 16-cycle repetition is too long
	always_ff @(posedge clk_sys)
	begin
		if (rst || !moduleReset)
			len_q <= 8'h00;
		else
			len_q <= len_q + 8'h01;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_PULSE_LEN: assert property ($fell(moduleReset) && !$past(rst)
		|-> len_q == DSW_RESET_PULSE) else $error("pulse too short");
	AST_PULSE_MAX: assert property (moduleReset
		|-> len_q < DSW_RESET_PULSE) else $error("pulse too long");
	AST_PIN_STICKY: assert property ($fell(watchdog_expiry_pin)
		|-> $past(rst)) else $error("pin cleared");
	AST_NMI_HOLD: assert property ($fell(nmiOut)
		|-> $past(wr) || $past(rst)) else $error("nmi dropped");
	AST_OSI_HOLD: assert property ($fell(os_control_interrupt)
		|-> $past(wr) || $past(rst)) else $error("os int dropped");
	AST_ONE_ACT: assert property ($rose(nmiOut)
		|-> !$rose(os_control_interrupt) && !$rose(moduleReset))
		else $error("two actions");
	AST_READY: assert property (acc |-> apbRsp.pready)
		else $error("no ready");
	AST_SLVERR: assert property (apbRsp.pslverr |-> acc)
		else $error("stray error");
endmodule
bind dsw_watchdog dsw_props dsw_props_inst (.clk_sys, .rst, .apbReq,
	.apbRsp, .moduleReset, .nmiOut, .os_control_interrupt,
	.watchdog_expiry_pin);

/* test/dsw_baseboard.sv */
`timescale 1ns/100ps
module dsw_baseboard
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic moduleReset,
	output logic [7:0] lastLen_q
);
	logic [7:0] run_q;
	// Board reset logic: length of the last reset pulse
	always_ff @(posedge clk_sys)
	begin
		run_q <= (moduleReset && !rst) ? run_q + 8'h01 : 8'h00;
		if (rst)
			lastLen_q <= 8'h00;
		else if (!moduleReset && run_q != 8'h00)
			lastLen_q <= run_q;
	end
endmodule

/* test/dual_stage_watchdog_tb.sv */
`timescale 1ns/100ps
module dual_stage_watchdog_tb
	import dsw_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	dsw_apb_req_type req = '0;
	dsw_apb_rsp_type rsp;
	logic modRst, nmi, osInt, pin, irq, err;
	logic [7:0] pLen;
	logic [31:0] rd;
	int mismatches = 0;
	int check_count = 0;
	int waited;
	wire [3:0] outs = {pin, osInt, nmi, modRst};
	initial forever #20 clk_sys = ~clk_sys;
	dsw_watchdog dsw_watchdog_inst (.clk_sys, .rst, .apbReq(req),
		.apbRsp(rsp), .moduleReset(modRst), .nmiOut(nmi),
		.os_control_interrupt(osInt), .watchdog_expiry_pin(pin), .irq);
	dsw_baseboard dsw_baseboard_inst (.clk_sys, .rst, .moduleReset(modRst),
		.lastLen_q(pLen));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic fail();
		mismatches++;
		wrap_up();
	endtask
	// Entered just after an edge; leaves one idle cycle behind
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1)
			fail();
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge clk_sys);
	endtask
	task automatic waitOn(int k);
		waited = 0;
		while (outs[k] !== 1'b1 && waited < 300)
		begin
			@(posedge clk_sys);
			waited++;
		end
		if (outs[k] !== 1'b1)
			fail();
	endtask
	function automatic logic [31:0] ctl(logic [2:0] a1, a2, logic ps);
		return {19'h0_0000, ps, 1'b0, a2, 1'b0, a1, 4'h1};
	endfunction
	task automatic tService();
		apb(1, DSW_OFS_PRESCALE, 0);
		apb(1, DSW_OFS_TOUT1, 32'h0000_0014);
		apb(1, DSW_OFS_IRQ_EN, 32'h0000_0001);
		apb(1, DSW_OFS_CTRL, ctl(DSW_ACT_NMI, 3'h7, 1'b1));
		repeat (8) apb(1, DSW_OFS_SERVICE, DSW_SERVICE_KEY);
		chk("early", outs, 0);
		waitOn(1);
		chk("nmi only", outs, 4'h2);
		chk("irq", irq, 1);
		apb(1, DSW_OFS_IRQ_EN, 0);
		chk("masked", irq, 0);
		apb(1, DSW_OFS_IRQ_EN, 32'h0000_0001);
		apb(1, DSW_OFS_IRQ_CLR, 32'h0000_0001);
		chk("cleared", irq, 0);
		chk("nmi held", nmi, 1);
		apb(1, DSW_OFS_SERVICE, DSW_SERVICE_KEY);
		chk("nmi off", nmi, 0);
		apb(1, DSW_OFS_CTRL, 0);
		$display("service done");
	endtask
	task automatic tCascade();
		apb(1, DSW_OFS_TOUT1, 32'h0000_0005);
		apb(1, DSW_OFS_TOUT2, 32'h0000_0008);
		apb(1, DSW_OFS_CTRL, ctl(DSW_ACT_CASCADE, DSW_ACT_OSINT, 1'b1));
		waitOn(2);
		chk("late", waited >= 13, 1);
		chk("pin", outs, 4'hC);
		apb(0, DSW_OFS_CTRL, 0);
		chk("idle", rd[0], 0);
		apb(0, DSW_OFS_IRQ_STAT, 0);
		chk("stat", rd, 3);
		apb(1, DSW_OFS_IRQ_CLR, 3);
		apb(1, DSW_OFS_SERVICE, DSW_SERVICE_KEY);
		chk("sticky", pin, 1);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk("pin rst", pin, 0);
		$display("cascade done");
	endtask
	task automatic tActs();
		int n;
		apb(1, DSW_OFS_PRESCALE, 0);
		apb(1, DSW_OFS_TOUT1, 32'h0000_0004);
		apb(1, DSW_OFS_CTRL, ctl(DSW_ACT_RESET, 3'h7, 1'b1));
		waitOn(0);
		repeat (20) @(posedge clk_sys);
		chk("len", pLen, DSW_RESET_PULSE);
		apb(1, DSW_OFS_TOUT2, 32'h0000_0004);
		apb(1, DSW_OFS_CTRL, ctl(DSW_ACT_PIN, DSW_ACT_DELAY, 1'b1));
		waitOn(3);
		chk("pin only", outs, 4'h8);
		n = 0;
		do
		begin
			apb(0, DSW_OFS_CTRL, 0);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 99);
		chk("done", rd[0], 0);
		chk("no delay 2", outs, 4'h8);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		apb(1, DSW_OFS_PRESCALE, 0);
		apb(1, DSW_OFS_TOUT1, 32'h0000_0004);
		apb(1, DSW_OFS_CTRL, ctl(DSW_ACT_CASCADE, 3'h7, 1'b0));
		waitOn(3);
		chk("sel stage1", outs, 4'h8);
		chk("pin at stage1", waited < 12, 1);
		$display("actions done");
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		apb(0, DSW_OFS_TOUT1, 0);
		chk("tout1", rd, DSW_TOUT_RST);
		apb(0, 8'h40, 0);
		chk("slverr", err, 1);
		tService();
		tCascade();
		tActs();
		wrap_up();
	end
endmodule
